// ==== design/ibc_pkg.sv ====
// constants shared by the bus controller configuration block
package ibc_pkg;
  // io addresses
  localparam logic [15:0] IO_CFG_LO    = 16'h00E8;
  localparam logic [15:0] IO_CFG_HI    = 16'h00EF;
  localparam logic [15:0] IO_INDEX     = 16'h00EC;
  localparam logic [15:0] IO_DATA      = 16'h00ED;
  localparam logic [15:0] IO_LOCK      = 16'h00F9;
  localparam logic [15:0] IO_UNLOCK    = 16'h00FB;
  // indexes
  localparam logic [7:0]  IX_SLEEP     = 8'h13;
  localparam logic [7:0]  IX_VERSION   = 8'h80;
  localparam logic [7:0]  IX_TIMING    = 8'h81;
  localparam logic [7:0]  IX_PAGE      = 8'h82;
  localparam logic [7:0]  IX_SLPTEST   = 8'h83;
  // reset values and reserved masks
  localparam logic [7:0]  TIMING_RST   = 8'hFC;
  localparam logic [7:0]  PAGE_RST     = 8'h3E;
  localparam logic [7:0]  PAGE_RSV     = 8'h3E;
  localparam logic [5:0]  SLEEP_RSV    = 6'h3F;
  // identification: values arbitrary
  localparam logic [5:0]  VER_ID       = 6'h15;
  localparam logic [1:0]  VER_REV      = 2'h0;
  // field positions
  localparam int          SLP_EN_BIT   = 7;
  localparam int          SLP_CLK_BIT  = 0;
  localparam int          TM_ROM_LSB   = 6;
  localparam int          TM_DMA8_LSB  = 4;
  localparam int          TM_DMA16_LSB = 2;
  localparam int          TM_DCLK_BIT  = 1;
  localparam int          TM_MEMR_BIT  = 0;
  localparam int          PG_EXT_BIT   = 7;
  localparam int          PG_4XX_BIT   = 6;
  localparam int          PG_UP_BIT    = 0;
  // board test
  localparam logic [7:0]  TEST_ON_PAT  = 8'hFF;
  localparam logic [7:0]  TEST_OFF_PAT = 8'h00;
  localparam int          TEST_PINS    = 8;
  localparam int          CLK_NS       = 4;
  localparam int          TEST_STB_NS  = 100;
  localparam int          TEST_STB_CYC = (TEST_STB_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    T_IDLE  = 3'b001,
    T_SEL   = 3'b010,
    T_ARMED = 3'b100
  } ibc_test_t;
endpackage

// ==== design/ibc_config.sv ====
// configuration, sleep and board-test logic of the isa bus controller
//
// Functional notes
// R01: sleep bit 7 set to 1 enters power-down; interrupts and timers run.
// R02: sleep register write-only at index 13h, read/write at 83h.
// R03: external or timer-zero interrupts still reach the cpu in power-down.
// R04: cpu clears sleep bit 7 after the wake interrupt to resume.
// R05: slot clock stops only when bit 0 is 0 and bit 7 is 1.
// R06: test select low, FFh, both strobes low 100 ns, select high enters.
// R07: board test ends on reset or the same sequence with 00h.
// R08: in board test outputs follow inputs; some outputs become inputs.
// R09: any write to 00FBh unlocks, any write to config_lock locks.
// R10: while locked, ports 00E8h to 00EFh are blocked.
// R11: protect bit set disables the lock and unlock mechanism.
// R12: write-only 8-bit index at 00ECh selects data port 00EDh target.
// R13: index writes latched here too; index reads never driven here.
// R14: answer only indexes 80h to FFh, plus the shared 13h; the code answers reads at 80h to 83h only.
// R15: version register 80h gives identification and revision.
// R16: timing bits 7-6 give rom wait states 3,1,2,3.
// R17: bits 5-4 and 3-2 give dma command length 2,4,3,3 clocks.
// R18: timing bit 1 selects slot clock or half slot clock for dma.
// R19: timing bit 0 makes dma memory read fall one dma clock early.
// R20: page bit 7 enables bits 24-25; strap not grounded holds 7-6 low.
// R21: page bit 6 allows upper page access at +400h and enables 24-25.
// R22: page bit 0 steers page writes upper or lower when extended.
// R23: reset clears sleep bit 7 and sets clock gating bit 0.
// R24: reserved bits of indexed registers read as one.
// R25: reads of lock and unlock addresses are not driven.
`timescale 1ns/10ps
`default_nettype none

module ibc_config (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            sys_rst,
  // io bus pins
  input  wire logic [15:0]                     io_addr,
  input  wire logic [7:0]                      peripheral_data_bus,
  input  wire logic                            io_rd_n,
  input  wire logic                            io_wr_n,
  output logic      [7:0]                      io_data_out,
  output logic                                 io_data_oe,
  // system side
  input  wire logic                            misc_settings_protect,
  input  wire logic                            cpu_type_strap,
  input  wire logic                            ext_irq,
  input  wire logic                            timer_zero,
  output logic                                 cpu_intr,
  // power-down and clocks
  output logic                                 power_down,
  output logic                                 slot_clk,
  output logic                                 dma_timing_clock,
  // timing settings
  output logic      [1:0]                      rom_wait_states,
  output logic      [2:0]                      dma8_cmd_clocks,
  output logic      [2:0]                      dma16_cmd_clocks,
  output logic                                 dma_memory_read_early,
  // page extension
  output logic                                 dma_addr_ext_enable,
  output logic                                 upper_page_io_enable,
  output logic                                 page_upper_select,
  // board test
  input  wire logic                            test_sel_n,
  input  wire logic [ibc_pkg::TEST_PINS-1:0]   test_in,
  output logic      [ibc_pkg::TEST_PINS-1:0]   test_out,
  output logic                                 test_out_oe,
  output logic                                 dual_pin_oe,
  output logic                                 board_test_mode
);

  localparam int TW = ibc_pkg::TEST_PINS;

  typedef struct packed {
    logic              rd_s1;
    logic              rd_s2;
    logic              wr_s1;
    logic              wr_s2;
    logic              sel_s1;
    logic              sel_s2;
    logic              strap_s1;
    logic              strap_s2;
    logic [15:0]       addr_s1;
    logic [15:0]       addr_s2;
    logic [7:0]        din_s1;
    logic [7:0]        din_s2;
    logic [TW-1:0]     tin_s1;
    logic [TW-1:0]     tin_s2;
    logic              wr_prev;
    logic [15:0]       wa;
    logic [7:0]        wd;
    logic              locked;
    logic [7:0]        index;
    logic [7:0]        timing;
    logic [7:0]        page;
    logic              slp_en;
    logic              slp_clk;
    logic [1:0]        div;
    logic              slot_clk;
    logic              dma_clk;
    logic              intr;
    logic [7:0]        rdata;
    logic              rdoe;
    ibc_pkg::ibc_test_t tst;
    logic [4:0]        tcnt;
    logic              tgt_on;
    logic              test_mode;
    logic [TW-1:0]     tout;
  } ibc_state_t;

  ibc_state_t    q;
  ibc_state_t    d;
  logic          wr_done;
  logic          rd_act;
  logic          cfg_open;
  logic          wa_in_cfg;
  logic          own_index;
  logic [TW-1:0] follow;

  // ************************************************************
  // board test pin mapping
  // ************************************************************
  // each output watches two neighbouring inputs so a short or open
  // on either joint changes what the tester sees
  genvar gi;
  generate
    for (gi = 0; gi < TW; gi++)
    begin : g_follow
      assign follow[gi] = q.tin_s2[gi] ^ q.tin_s2[(gi + 1) % TW]; // R08
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d         = q;
    cfg_open  = !q.locked || misc_settings_protect; // R10 R11
    wa_in_cfg = (q.wa >= ibc_pkg::IO_CFG_LO) &&
                (q.wa <= ibc_pkg::IO_CFG_HI);
    own_index = (q.index[7] == 1'b1); // R14
    // writes commit on the rising strobe; ignored during test select
    wr_done   = q.wr_s2 && !q.wr_prev && q.sel_s2;
    rd_act    = !q.rd_s2 && q.wr_s2 && q.sel_s2 && cfg_open &&
                (q.addr_s2 == ibc_pkg::IO_DATA) && own_index &&
                (q.index <= ibc_pkg::IX_SLPTEST); // R13 R14 R25
    // pin synchronisers
    d.rd_s1    = io_rd_n;
    d.rd_s2    = q.rd_s1;
    d.wr_s1    = io_wr_n;
    d.wr_s2    = q.wr_s1;
    d.sel_s1   = test_sel_n;
    d.sel_s2   = q.sel_s1;
    d.strap_s1 = cpu_type_strap;
    d.strap_s2 = q.strap_s1;
    d.addr_s1  = io_addr;
    d.addr_s2  = q.addr_s1;
    d.din_s1   = peripheral_data_bus;
    d.din_s2   = q.din_s1;
    d.tin_s1   = test_in;
    d.tin_s2   = q.tin_s1;
    d.wr_prev  = q.wr_s2;
    if (!q.wr_s2)
    begin
      d.wa = q.addr_s2;
      d.wd = q.din_s2;
    end
    // lock and unlock ignore the data written
    if (wr_done && !misc_settings_protect)
    begin
      if (q.wa == ibc_pkg::IO_UNLOCK)
        d.locked = 1'b0; // R09
      if (q.wa == ibc_pkg::IO_LOCK)
        d.locked = 1'b1; // R09
    end
    if (wr_done && cfg_open && wa_in_cfg)
    begin
      if (q.wa == ibc_pkg::IO_INDEX)
        d.index = q.wd; // R12 R13
      if (q.wa == ibc_pkg::IO_DATA)
      begin
        case (q.index)
          ibc_pkg::IX_SLEEP, ibc_pkg::IX_SLPTEST:
          begin
            // clearing bit 7 here is how the cpu wakes the block
            d.slp_en  = q.wd[ibc_pkg::SLP_EN_BIT]; // R01 R02 R04
            d.slp_clk = q.wd[ibc_pkg::SLP_CLK_BIT]; // R05
          end
          ibc_pkg::IX_TIMING:
            d.timing = q.wd; // R16 R17
          ibc_pkg::IX_PAGE:
            d.page = q.wd | ibc_pkg::PAGE_RSV; // R24
          default:
            d.index = q.index;
        endcase
      end
    end
    // strap not grounded pins the extension bits low
    if (q.strap_s2)
    begin
      d.page[ibc_pkg::PG_EXT_BIT] = 1'b0; // R20
      d.page[ibc_pkg::PG_4XX_BIT] = 1'b0; // R20
    end
    // read data, registered so the bus sees a flop
    d.rdoe = rd_act;
    case (q.index)
      ibc_pkg::IX_VERSION:
        d.rdata = {ibc_pkg::VER_ID, ibc_pkg::VER_REV}; // R15
      ibc_pkg::IX_TIMING:
        d.rdata = q.timing;
      ibc_pkg::IX_PAGE:
        d.rdata = q.page;
      ibc_pkg::IX_SLPTEST:
        d.rdata = {q.slp_en, ibc_pkg::SLEEP_RSV, q.slp_clk}; // R02 R24
      default:
        d.rdata = 8'h00;
    endcase
    // slot clock is core clock over two; gated only in power-down
    d.div = q.div + 2'h1;
    if (q.slp_en && !q.slp_clk)
      d.slot_clk = 1'b0; // R05
    else
      d.slot_clk = !q.slot_clk; // R05
    if (q.slp_en)
      d.dma_clk = 1'b0; // R01
    else if (q.timing[ibc_pkg::TM_DCLK_BIT])
      d.dma_clk = d.slot_clk; // R18
    else
      d.dma_clk = q.div[1]; // R18
    // interrupts bypass the sleep gating entirely
    d.intr = ext_irq || timer_zero; // R03
    // board test entry and exit sequence
    case (q.tst)
      ibc_pkg::T_IDLE:
      begin
        d.tcnt = 5'h00;
        if (!q.sel_s2)
          d.tst = ibc_pkg::T_SEL;
      end
      ibc_pkg::T_SEL:
      begin
        if (q.sel_s2)
          d.tst = ibc_pkg::T_IDLE;
        else if (!q.rd_s2 && !q.wr_s2)
        begin
          if (q.tcnt != 5'h1F)
            d.tcnt = q.tcnt + 5'h01;
          if ((q.tcnt >= 5'(ibc_pkg::TEST_STB_CYC - 1)) &&
              ((q.din_s2 == ibc_pkg::TEST_ON_PAT) ||
               (q.din_s2 == ibc_pkg::TEST_OFF_PAT)))
          begin
            d.tgt_on = (q.din_s2 == ibc_pkg::TEST_ON_PAT); // R06 R07
            d.tst    = ibc_pkg::T_ARMED;
          end
        end
        else
          d.tcnt = 5'h00; // R06
      end
      ibc_pkg::T_ARMED:
      begin
        if (q.sel_s2)
        begin
          d.test_mode = q.tgt_on; // R06 R07
          d.tst       = ibc_pkg::T_IDLE;
        end
      end
      default:
        d.tst = ibc_pkg::T_IDLE;
    endcase
    d.tout = q.test_mode ? follow : '0; // R08
    if (sys_rst)
    begin
      d          = '0;
      d.rd_s1    = 1'b1;
      d.rd_s2    = 1'b1;
      d.wr_s1    = 1'b1;
      d.wr_s2    = 1'b1;
      d.wr_prev  = 1'b1;
      d.sel_s1   = 1'b1;
      d.sel_s2   = 1'b1;
      d.timing   = ibc_pkg::TIMING_RST;
      d.page     = ibc_pkg::PAGE_RST;
      d.slp_clk  = 1'b1; // R23
      d.tst      = ibc_pkg::T_IDLE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign io_data_out           = q.rdata;
  assign io_data_oe            = q.rdoe;
  assign cpu_intr              = q.intr;
  assign power_down            = q.slp_en;
  assign slot_clk              = q.slot_clk;
  assign dma_timing_clock      = q.dma_clk;
  assign board_test_mode       = q.test_mode;
  assign test_out              = q.tout;
  assign test_out_oe           = q.test_mode; // R06
  assign dual_pin_oe           = !q.test_mode; // R08
  assign dma_memory_read_early = q.timing[ibc_pkg::TM_MEMR_BIT]; // R19

  always_comb
  begin
    case (q.timing[ibc_pkg::TM_ROM_LSB +: 2])
      2'b01:   rom_wait_states = 2'd1; // R16
      2'b10:   rom_wait_states = 2'd2; // R16
      default: rom_wait_states = 2'd3; // R16
    endcase
    case (q.timing[ibc_pkg::TM_DMA8_LSB +: 2])
      2'b00:   dma8_cmd_clocks = 3'd2; // R17
      2'b01:   dma8_cmd_clocks = 3'd4; // R17
      default: dma8_cmd_clocks = 3'd3; // R17
    endcase
    case (q.timing[ibc_pkg::TM_DMA16_LSB +: 2])
      2'b00:   dma16_cmd_clocks = 3'd2; // R17
      2'b01:   dma16_cmd_clocks = 3'd4; // R17
      default: dma16_cmd_clocks = 3'd3; // R17
    endcase
  end

  assign dma_addr_ext_enable  = q.page[ibc_pkg::PG_EXT_BIT] ||
                                q.page[ibc_pkg::PG_4XX_BIT]; // R20 R21
  assign upper_page_io_enable = q.page[ibc_pkg::PG_4XX_BIT]; // R21
  assign page_upper_select    = dma_addr_ext_enable &&
                                q.page[ibc_pkg::PG_UP_BIT]; // R22

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_strobes_low;
    !q.sel_s2 && !q.rd_s2 && !q.wr_s2;
  endsequence
  sequence s_sel_release;
    q.tst == ibc_pkg::T_ARMED && q.sel_s2;
  endsequence

  unlock_write_a: assert property (wr_done && !misc_settings_protect && // R09
      q.wa == ibc_pkg::IO_UNLOCK |=> !q.locked)
    else $error("unlock write did not unlock");
  lock_write_a: assert property (wr_done && !misc_settings_protect && // R09
      q.wa == ibc_pkg::IO_LOCK |=> q.locked)
    else $error("lock write did not lock");
  locked_block_a: assert property (q.locked && !misc_settings_protect // R10
      |=> !io_data_oe)
    else $error("data driven while locked");
  index_range_a: assert property (io_data_oe |-> // R14
      $past(q.index) >= ibc_pkg::IX_VERSION &&
      $past(q.addr_s2) == ibc_pkg::IO_DATA)
    else $error("data driven outside own index range");
  version_read_a: assert property (rd_act && // R15
      q.index == ibc_pkg::IX_VERSION |=> io_data_out ==
      {ibc_pkg::VER_ID, ibc_pkg::VER_REV})
    else $error("version read wrong");
  slot_stop_a: assert property ((q.slp_en && !q.slp_clk) [*2] // R05
      |-> !slot_clk)
    else $error("slot clock ran while gated");
  slot_run_a: assert property (!sys_rst && !q.slp_en ##1 !q.slp_en // R05
      |-> slot_clk != $past(slot_clk))
    else $error("slot clock stalled out of power-down");
  strap_hold_a: assert property (q.strap_s2 |=> // R20
      q.page[ibc_pkg::PG_EXT_BIT +: 1] == 1'b0 && !upper_page_io_enable)
    else $error("extension bits set with strap high");
  intr_pass_a: assert property (ext_irq || timer_zero |=> cpu_intr) // R03
    else $error("interrupt not forwarded");
  test_enter_a: assert property (s_sel_release |=> // R06 R07
      board_test_mode == $past(q.tgt_on))
    else $error("board test mode not updated on select release");
  test_arm_a: assert property (s_strobes_low [*8] ##1 // R06
      q.tst == ibc_pkg::T_ARMED |-> $past(q.tcnt) >= 5'd24)
    else $error("armed before the strobe time");
  reset_val_a: assert property (@(posedge core_clk) disable iff (1'b0) // R23
      sys_rst ##1 !sys_rst |->
      !power_down && q.slp_clk && q.timing == ibc_pkg::TIMING_RST)
    else $error("reset values wrong");

endmodule

`default_nettype wire

// ==== tb/ibc_host_model.sv ====
// host cpu and board tester model that drives the io pins of the block
`timescale 1ns/10ps
`default_nettype none

module ibc_host_model (
  // clock
  input  wire logic        core_clk,
  // io bus pins
  output var  logic [15:0] io_addr,
  output var  logic [7:0]  peripheral_data_bus,
  output var  logic        io_rd_n,
  output var  logic        io_wr_n,
  output var  logic        test_sel_n,
  // read answer
  input  wire logic [7:0]  io_data_out,
  input  wire logic        io_data_oe
);
  // ****************
  // idle pins
  // ****************
  initial
  begin
    io_addr             = 16'h0000;
    peripheral_data_bus = 8'h00;
    io_rd_n             = 1'b1;
    io_wr_n             = 1'b1;
    test_sel_n          = 1'b1;
  end

  // ****************
  // bus cycles
  // ****************
  // released lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr             <= a;
    peripheral_data_bus <= d;
    io_wr_n             <= 1'b0;
    repeat (3) @(posedge core_clk);
    io_wr_n             <= 1'b1;
    io_addr             <= ~a;
    peripheral_data_bus <= ~d;
    repeat (5) @(posedge core_clk);
  endtask

  // strobe held until the answer is seen, or 8 cycles if nobody drives
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic drv);
    d       = 8'h00;
    drv     = 1'b0;
    io_addr <= a;
    io_rd_n <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      if (io_data_oe === 1'b1)
      begin
        drv = 1'b1;
        d   = io_data_out;
        break;
      end
    end
    io_rd_n <= 1'b1;
    io_addr <= ~a;
    repeat (5) @(posedge core_clk);
  endtask

  // select low, pattern, both strobes low for n cycles, select high
  task automatic test_seq(input logic [7:0] pat, input int n);
    test_sel_n          <= 1'b0;
    peripheral_data_bus <= pat;
    repeat (3) @(posedge core_clk);
    io_rd_n <= 1'b0;
    io_wr_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    test_sel_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// ==== tb/isa_bus_ctrl_config_sleep_test_tb_top.sv ====
// self-checking bench of the configuration, sleep and board-test block
`timescale 1ns/10ps
`default_nettype none

module isa_bus_ctrl_config_sleep_test_tb_top;
  logic        core_clk, sys_rst, io_rd_n, io_wr_n, test_sel_n;
  logic        io_data_oe, misc_settings_protect, cpu_type_strap;
  logic        ext_irq, timer_zero, cpu_intr, power_down, slot_clk;
  logic        dma_timing_clock, dma_memory_read_early, prev_s, prev_d;
  logic        dma_addr_ext_enable, upper_page_io_enable;
  logic        page_upper_select, test_out_oe, dual_pin_oe;
  logic        board_test_mode;
  logic [1:0]  rom_wait_states;
  logic [2:0]  dma8_cmd_clocks, dma16_cmd_clocks;
  logic [7:0]  peripheral_data_bus, io_data_out, test_in, test_out;
  logic [15:0] io_addr;
  int          error_cnt, n_compared, cyc, tog_s, tog_d;
  localparam logic [7:0] ROM_WS [4] = '{8'h03, 8'h01, 8'h02, 8'h03};
  localparam logic [7:0] DMA_CK [4] = '{8'h02, 8'h04, 8'h03, 8'h03};
  localparam logic [7:0] PG_WR  [4] = '{8'h81, 8'h01, 8'h40, 8'h41};
  localparam logic [7:0] PG_RD  [4] = '{8'hBF, 8'h3F, 8'h7E, 8'h7F};
  localparam logic [7:0] PG_OUT [4] = '{8'h05, 8'h00, 8'h06, 8'h07};
  localparam logic [7:0] NO_IX  [5] = '{8'h13, 8'h00, 8'h7F, 8'h84, 8'hFF};
  localparam logic [7:0] VER = {ibc_pkg::VER_ID, ibc_pkg::VER_REV};

  ibc_host_model host (
    .core_clk(core_clk), .io_addr(io_addr),
    .peripheral_data_bus(peripheral_data_bus), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .test_sel_n(test_sel_n),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe)
  );

  ibc_config uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .peripheral_data_bus(peripheral_data_bus), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .misc_settings_protect(misc_settings_protect),
    .cpu_type_strap(cpu_type_strap), .ext_irq(ext_irq),
    .timer_zero(timer_zero), .cpu_intr(cpu_intr),
    .power_down(power_down), .slot_clk(slot_clk),
    .dma_timing_clock(dma_timing_clock),
    .rom_wait_states(rom_wait_states), .dma8_cmd_clocks(dma8_cmd_clocks),
    .dma16_cmd_clocks(dma16_cmd_clocks),
    .dma_memory_read_early(dma_memory_read_early),
    .dma_addr_ext_enable(dma_addr_ext_enable),
    .upper_page_io_enable(upper_page_io_enable),
    .page_upper_select(page_upper_select), .test_sel_n(test_sel_n),
    .test_in(test_in), .test_out(test_out), .test_out_oe(test_out_oe),
    .dual_pin_oe(dual_pin_oe), .board_test_mode(board_test_mode)
  );

  // ****************
  // clock, watchdog, toggle counters
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc    <= cyc + 1;
    prev_s <= slot_clk;
    prev_d <= dma_timing_clock;
    if (slot_clk !== prev_s)
      tog_s <= tog_s + 1;
    if (dma_timing_clock !== prev_d)
      tog_d <= tog_d + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic cw(input logic [7:0] ix, input logic [7:0] d);
    host.wr(16'h00EC, ix);
    host.wr(16'h00ED, d);
  endtask

  task automatic cr(input logic [7:0] ix, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic       drv;
    host.wr(16'h00EC, ix);
    host.rd(16'h00ED, d, drv);
    chk({nm, " oe"}, 8'(drv), 8'h01);
    chk(nm, d, e);
  endtask

  task automatic nodrv(input logic [15:0] a, input string nm);
    logic [7:0] d;
    logic       drv;
    host.rd(a, d, drv);
    chk(nm, 8'(drv), 8'h00);
  endtask

  // slot and dma clock edges over eight cycles
  task automatic tog(output int ns, output int nd);
    int a, b;
    // let the register write settle so the window starts on a steady phase
    repeat (2) @(posedge core_clk);
    a = tog_s;
    b = tog_d;
    repeat (8) @(posedge core_clk);
    ns = tog_s - a;
    nd = tog_d - b;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    cr(8'h81, 8'hFC, "timing");
    cr(8'h82, 8'h3E, "page");
    cr(8'h83, 8'h7F, "sleep view");
    cr(8'h80, VER, "version");
    chk("rom ws", 8'(rom_wait_states), 8'h03);
    chk("dma8", 8'(dma8_cmd_clocks), 8'h03);
    chk("pdown", 8'(power_down), 8'h00);
  endtask

  task automatic t_sleep;
    int ns, nd;
    cw(8'h13, 8'h80);
    tog(ns, nd);
    chk("pdown on", 8'(power_down), 8'h01);
    chk("slot stop", 8'(ns), 8'h00);
    chk("slot low", 8'(slot_clk), 8'h00);
    chk("dclk stop", 8'(nd), 8'h00);
    ext_irq <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("intr ext", 8'(cpu_intr), 8'h01);
    ext_irq    <= 1'b0;
    timer_zero <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("intr tmr", 8'(cpu_intr), 8'h01);
    timer_zero <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("intr off", 8'(cpu_intr), 8'h00);
    cr(8'h83, 8'hFE, "sleep rd");
    cw(8'h83, 8'h81);
    tog(ns, nd);
    chk("slot run", 8'(ns), 8'h08);
    cw(8'h13, 8'h01);
    tog(ns, nd);
    chk("pdown off", 8'(power_down), 8'h00);
    chk("dclk half", 8'(nd), 8'h04);
  endtask

  task automatic t_timing;
    logic [1:0] c;
    int         ns, nd;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      cw(8'h81, {c, c, c, c});
      cr(8'h81, {c, c, c, c}, "timing rw");
      chk("rom ws", 8'(rom_wait_states), ROM_WS[i]);
      chk("dma8", 8'(dma8_cmd_clocks), DMA_CK[i]);
      chk("dma16", 8'(dma16_cmd_clocks), DMA_CK[i]);
      chk("early", 8'(dma_memory_read_early), 8'(c[0]));
      tog(ns, nd);
      chk("dclk", 8'(nd), c[1] ? 8'h08 : 8'h04);
    end
  endtask

  task automatic t_lock;
    host.wr(16'h00F9, 8'h5A);
    nodrv(16'h00ED, "locked rd");
    cw(8'h81, 8'h00);
    nodrv(16'h00F9, "lock rd");
    nodrv(16'h00FB, "unlock rd");
    host.wr(16'h00FB, 8'hA5);
    cr(8'h81, 8'hFF, "lock kept");
    misc_settings_protect <= 1'b1;
    host.wr(16'h00F9, 8'h00);
    misc_settings_protect <= 1'b0;
    cr(8'h81, 8'hFF, "protect");
    host.wr(16'h00F9, 8'h00);
    misc_settings_protect <= 1'b1;
    cr(8'h81, 8'hFF, "protect open");
    misc_settings_protect <= 1'b0;
    host.wr(16'h00FB, 8'h00);
  endtask

  task automatic t_index;
    logic [7:0] d;
    logic       drv;
    host.wr(16'h00EC, 8'h80);
    nodrv(16'h00EC, "index rd");
    host.rd(16'h00ED, d, drv);
    chk("index held", d, VER);
    cw(8'h80, 8'h00);
    cr(8'h80, VER, "version ro");
    for (int i = 0; i < 5; i++)
    begin
      host.wr(16'h00EC, NO_IX[i]);
      nodrv(16'h00ED, "foreign ix");
    end
  endtask

  task automatic t_page;
    for (int i = 0; i < 4; i++)
    begin
      cw(8'h82, PG_WR[i]);
      cr(8'h82, PG_RD[i], "page rw");
      chk("page ctl", 8'({dma_addr_ext_enable, upper_page_io_enable,
          page_upper_select}), PG_OUT[i]);
    end
    cpu_type_strap <= 1'b1;
    repeat (4) @(posedge core_clk);
    cw(8'h82, 8'hC1);
    cr(8'h82, 8'h3F, "strap");
    chk("strap ext", 8'(dma_addr_ext_enable), 8'h00);
    cpu_type_strap <= 1'b0;
  endtask

  task automatic t_test;
    host.test_seq(8'hFF, 10);
    chk("short", 8'(board_test_mode), 8'h00);
    host.test_seq(8'hFF, 30);
    chk("test on", 8'(board_test_mode), 8'h01);
    chk("test oe", 8'({test_out_oe, dual_pin_oe}), 8'h02);
    chk("test out", test_out, test_in ^ {test_in[0], test_in[7:1]});
    test_in <= 8'h3C;
    repeat (4) @(posedge core_clk);
    chk("test out2", test_out, 8'h3C ^ 8'h1E);
    host.test_seq(8'h00, 30);
    chk("test off", 8'(board_test_mode), 8'h00);
    chk("out idle", test_out, 8'h00);
    host.test_seq(8'hFF, 30);
    do_reset();
    chk("test rst", 8'(board_test_mode), 8'h00);
  endtask

  initial
  begin
    sys_rst               = 1'b1;
    misc_settings_protect = 1'b0;
    cpu_type_strap        = 1'b0;
    ext_irq               = 1'b0;
    timer_zero            = 1'b0;
    test_in               = 8'hA5;
    do_reset();
    t_reset();
    t_sleep();
    t_timing();
    t_lock();
    t_index();
    t_page();
    t_test();
    results();
  end
endmodule

`default_nettype wire
